// ==== rtl/mtl_cfg.svh ====
// Offsets, field positions and reset values of the trap and level-check unit.
// Assumes a 32-bit classic Wishbone slave decoding byte addresses on adr[7:0].
`ifndef MTL_CFG_SVH
`define MTL_CFG_SVH

`define MTL_ADR_W 8
`define MTL_ADR_STATUS 8'h00
`define MTL_ADR_ACCESS 8'h04
`define MTL_ADR_PERMIT 8'h08
`define MTL_ADR_IRQ_STAT 8'h0C
`define MTL_ADR_IRQ_MASK 8'h10
`define MTL_ADR_RESULT 8'h14

`define MTL_STATUS_W 8
`define MTL_STATUS_RST 8'h00
`define MTL_ACCESS_RST 32'h0000_0000
`define MTL_ACC_WIDTH_LSB 0
`define MTL_ACC_WIDTH_MSB 2
`define MTL_ACC_LEN_BIT 8
`define MTL_PERMIT_RST 32'h0000_0000

`define MTL_IRQ_W 3
`define MTL_IRQ_TRAP 0
`define MTL_IRQ_LEVEL 1
`define MTL_IRQ_UNIMPL 2
`define MTL_IRQ_RST 3'h0

`define MTL_COND_MAX 6'h0F
`define MTL_CHK_EXT 13'h0500

`endif

// ==== rtl/mtl_pkg.sv ====
// Types shared by the trap and level-check unit and its helpers.
// Assumes mtl_cfg.svh is on the include path.
package mtl_pkg;
  typedef enum logic [1:0] {
    MTL_ST_IDLE = 2'b00,
    MTL_ST_WAIT_REG = 2'b01,
    MTL_ST_EVAL = 2'b10
  } mtl_state_e;

  typedef enum logic [1:0] {
    MTL_OP_TRAP = 2'b00,
    MTL_OP_CHK_PERMIT = 2'b01,
    MTL_OP_CHK_AREG = 2'b10,
    MTL_OP_NONE = 2'b11
  } mtl_op_e;

  typedef enum logic [1:0] {
    MTL_DIR_PROCEED = 2'b00,
    MTL_DIR_TRAP = 2'b01,
    MTL_DIR_LEVEL_EXC = 2'b10,
    MTL_DIR_UNIMPL = 2'b11
  } mtl_dir_e;
endpackage

// ==== rtl/mtl_if.sv ====
// Carriers between the top of the unit and its two evaluators.
// Assumes both ends share one clock domain; all signals are combinational.
interface mtl_cond_if;
  logic [5:0] code;
  logic [7:0] flags;
  logic defined;
  logic is_true;
  modport eval (input code, input flags, output defined, output is_true);
  modport user (output code, output flags, input defined, input is_true);
endinterface

interface mtl_lvl_if;
  logic [31:0] src;
  logic [31:0] dst;
  logic [2:0] width;
  logic enable;
  logic exc;
  modport eval (input src, input dst, input width, input enable, output exc);
  modport user (output src, output dst, output width, output enable, input exc);
endinterface

// ==== rtl/mtl_cond_eval.sv ====
// Evaluates a six-bit condition code against the eight status flags.
// Assumes flags are ordered bus error, limit, supervisor, access level,
// write protect, invalid, gate, globally shared from bit 0 upward.
`include "mtl_cfg.svh"
module mtl_cond_eval (
  mtl_cond_if.eval c   // Condition code in, verdict out
);
  always_comb begin
    c.defined = (c.code <= `MTL_COND_MAX);
    // Bits 3:1 pick the flag, bit 0 asks for it clear
    c.is_true = c.flags[c.code[3:1]] ^ c.code[0];
  end
endmodule

// ==== rtl/mtl_level_cmp.sv ====
// Compares the upper access-level bits of a source and a destination pointer.
// Assumes width selects width+1 upper bits, from one to eight.
module mtl_level_cmp (
  mtl_lvl_if.eval l   // Operands in, exception verdict out
);
  logic [3:0] shamt;
  logic [31:0] mask;

  always_comb begin
    shamt = {1'b0, l.width} + 4'h1;
    mask = ~(32'hFFFF_FFFF >> shamt);
    // Disabled levels always fault; otherwise larger source is less privileged
    l.exc = !l.enable || ((l.src & mask) > (l.dst & mask));
  end
endmodule

// ==== rtl/mtl_unit.sv ====
// Trap-on-condition and pointer privilege check unit with a Wishbone register file.
// Assumes the host fetches all words, forwards one command at a time and
// carries out the directive returned on the response port.
//
// Contract
// - True condition answers trap directive; host traps, stacking next instruction address.
// - False condition answers proceed directive; nothing else happens.
// - Code bits 3:1 select one of eight flags; bit 0 tests clear.
// - Host forwards the condition word; unit answers with completion directives.
// - Neither instruction changes any translation status register bit.
// - Compare upper access-level bits; count from compare width field.
// - Source greater than destination raises access level exception, else proceed.
// - Level enable field zero always raises access level exception.
// - First check form takes source level from permitted privilege register.
// - Second check form fetches source from address register named by field.
//
// Chosen here: the register addresses and the Wishbone interface to the registers.
`include "mtl_cfg.svh"
module mtl_unit
  import mtl_pkg::*;
(
  input wire logic clk_i,                       // Clock, 250 MHz
  input wire logic rst_i,                       // Synchronous reset, active high
  input wire logic wb_cyc_i,                    // Wishbone cycle
  input wire logic wb_stb_i,                    // Wishbone strobe
  input wire logic wb_we_i,                     // Wishbone write enable
  input wire logic [`MTL_ADR_W-1:0] wb_adr_i,   // Wishbone byte address
  input wire logic [3:0] wb_sel_i,              // Wishbone byte selects
  input wire logic [31:0] wb_dat_i,             // Wishbone write data
  output logic [31:0] wb_dat_o,                 // Wishbone read data
  output logic wb_ack_o,                        // Wishbone acknowledge
  input wire logic cmd_valid_i,                 // Host offers a command
  output logic cmd_ready_o,                     // Unit can take a command
  input wire logic [1:0] cmd_op_i,              // Command kind, mtl_op_e
  input wire logic [15:0] cmd_word_i,           // Condition or extension word
  input wire logic [31:0] cmd_ea_i,             // Destination pointer operand
  output logic reg_req_o,                       // Asks host for an address register
  output logic [2:0] reg_sel_o,                 // Address register number wanted
  input wire logic reg_valid_i,                 // Host supplies register contents
  input wire logic [31:0] reg_data_i,           // Address register contents
  output logic rsp_valid_o,                     // Directive valid, one cycle
  output logic [1:0] rsp_dir_o,                 // Directive, mtl_dir_e
  output logic irq_o                            // Level interrupt
);

  mtl_cond_if cond_c ();
  mtl_lvl_if lvl_c ();

  mtl_cond_eval u_cond (
    .c (cond_c)
  );

  mtl_level_cmp u_lvl (
    .l (lvl_c)
  );

  function automatic logic chk_ext_ok(input logic [15:0] w, input logic [1:0] op);
    logic ok;
    ok = (w[15:3] == `MTL_CHK_EXT);
    if (op == MTL_OP_CHK_PERMIT) begin
      ok = ok && (w[2:0] == 3'h0);
    end
    return ok;
  endfunction

  function automatic logic [31:0] merge_bytes(input logic [31:0] old,
                                              input logic [31:0] wdat,
                                              input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = wdat[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Command sequencing state
  mtl_state_e state_ff, nxt_state;
  mtl_op_e op_ff, nxt_op;
  logic [15:0] word_ff, nxt_word;
  logic [31:0] src_ff, nxt_src;
  logic [31:0] dst_ff, nxt_dst;
  logic ready_ff, nxt_ready;
  logic req_ff, nxt_req;
  logic [2:0] sel_ff, nxt_sel;
  logic rsp_valid_ff, nxt_rsp_valid;
  mtl_dir_e dir_ff, nxt_dir;
  mtl_dir_e eval_dir;
  logic [15:0] cnt_ff, nxt_cnt;
  logic ev_trap, ev_level, ev_unimpl;

  // Register file state
  logic [`MTL_STATUS_W-1:0] status_ff, nxt_status;
  logic [31:0] access_ff, nxt_access;
  logic [31:0] permit_ff, nxt_permit;
  logic [`MTL_IRQ_W-1:0] istat_ff, nxt_istat;
  logic [`MTL_IRQ_W-1:0] imask_ff, nxt_imask;
  logic [31:0] rdat_ff, nxt_rdat;
  logic ack_ff, nxt_ack;
  logic irq_ff, nxt_irq;

  assign cond_c.code = word_ff[5:0];
  assign cond_c.flags = status_ff;
  assign lvl_c.src = src_ff;
  assign lvl_c.dst = dst_ff;
  assign lvl_c.width = access_ff[`MTL_ACC_WIDTH_MSB:`MTL_ACC_WIDTH_LSB];
  assign lvl_c.enable = access_ff[`MTL_ACC_LEN_BIT];

  always_comb begin
    eval_dir = MTL_DIR_UNIMPL;
    case (op_ff)
      MTL_OP_TRAP: begin
        if (word_ff[15:6] == 10'h000 && cond_c.defined) begin
          eval_dir = cond_c.is_true ? MTL_DIR_TRAP : MTL_DIR_PROCEED;
        end
      end
      MTL_OP_CHK_PERMIT, MTL_OP_CHK_AREG: begin
        if (chk_ext_ok(word_ff, op_ff)) begin
          eval_dir = lvl_c.exc ? MTL_DIR_LEVEL_EXC : MTL_DIR_PROCEED;
        end
      end
      default: begin
        eval_dir = MTL_DIR_UNIMPL;
      end
    endcase
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_op = op_ff;
    nxt_word = word_ff;
    nxt_src = src_ff;
    nxt_dst = dst_ff;
    nxt_ready = ready_ff;
    nxt_req = req_ff;
    nxt_sel = sel_ff;
    nxt_rsp_valid = 1'b0;
    nxt_dir = dir_ff;
    nxt_cnt = cnt_ff;
    ev_trap = 1'b0;
    ev_level = 1'b0;
    ev_unimpl = 1'b0;
    case (state_ff)
      MTL_ST_IDLE: begin
        if (cmd_valid_i && ready_ff) begin
          nxt_op = mtl_op_e'(cmd_op_i);
          nxt_word = cmd_word_i;
          nxt_dst = cmd_ea_i;
          nxt_src = permit_ff;
          nxt_ready = 1'b0;
          if (cmd_op_i == MTL_OP_CHK_AREG && chk_ext_ok(cmd_word_i, cmd_op_i)) begin
            nxt_req = 1'b1;
            nxt_sel = cmd_word_i[2:0];
            nxt_state = MTL_ST_WAIT_REG;
          end else begin
            nxt_state = MTL_ST_EVAL;
          end
        end
      end
      MTL_ST_WAIT_REG: begin
        // The host may take any number of cycles to read its register
        if (reg_valid_i) begin
          nxt_src = reg_data_i;
          nxt_req = 1'b0;
          nxt_state = MTL_ST_EVAL;
        end
      end
      MTL_ST_EVAL: begin
        nxt_rsp_valid = 1'b1;
        nxt_dir = eval_dir;
        nxt_ready = 1'b1;
        nxt_cnt = cnt_ff + 16'h0001;
        ev_trap = (eval_dir == MTL_DIR_TRAP);
        ev_level = (eval_dir == MTL_DIR_LEVEL_EXC);
        ev_unimpl = (eval_dir == MTL_DIR_UNIMPL);
        nxt_state = MTL_ST_IDLE;
      end
      default: begin
        nxt_state = MTL_ST_IDLE;
        nxt_ready = 1'b1;
        nxt_req = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= MTL_ST_IDLE;
      op_ff <= MTL_OP_NONE;
      word_ff <= 16'h0000;
      src_ff <= 32'h0000_0000;
      dst_ff <= 32'h0000_0000;
      ready_ff <= 1'b1;
      req_ff <= 1'b0;
      sel_ff <= 3'h0;
      rsp_valid_ff <= 1'b0;
      dir_ff <= MTL_DIR_PROCEED;
      cnt_ff <= 16'h0000;
    end else begin
      state_ff <= nxt_state;
      op_ff <= nxt_op;
      word_ff <= nxt_word;
      src_ff <= nxt_src;
      dst_ff <= nxt_dst;
      ready_ff <= nxt_ready;
      req_ff <= nxt_req;
      sel_ff <= nxt_sel;
      rsp_valid_ff <= nxt_rsp_valid;
      dir_ff <= nxt_dir;
      cnt_ff <= nxt_cnt;
    end
  end

  // Register bus: one wait state, writes land on the edge that raises ack
  always_comb begin
    logic wr;
    logic rd;
    logic [`MTL_IRQ_W-1:0] w1c;
    logic [31:0] wmask;
    wr = 1'b0;
    rd = 1'b0;
    w1c = '0;
    wmask = merge_bytes(32'h0000_0000, 32'hFFFF_FFFF, wb_sel_i);
    nxt_status = status_ff;
    nxt_access = access_ff;
    nxt_permit = permit_ff;
    nxt_imask = imask_ff;
    nxt_rdat = rdat_ff;
    nxt_ack = wb_cyc_i && wb_stb_i && !ack_ff;
    wr = nxt_ack && wb_we_i;
    rd = nxt_ack && !wb_we_i;
    if (wr) begin
      case (wb_adr_i)
        // Status flags are owned by software; instructions only read them
        `MTL_ADR_STATUS: begin
          nxt_status = wb_sel_i[0] ? wb_dat_i[`MTL_STATUS_W-1:0] : status_ff;
        end
        `MTL_ADR_ACCESS: begin
          nxt_access = merge_bytes(access_ff, wb_dat_i, wb_sel_i);
        end
        `MTL_ADR_PERMIT: begin
          nxt_permit = merge_bytes(permit_ff, wb_dat_i, wb_sel_i);
        end
        `MTL_ADR_IRQ_STAT: begin
          w1c = wb_dat_i[`MTL_IRQ_W-1:0] & wmask[`MTL_IRQ_W-1:0];
        end
        `MTL_ADR_IRQ_MASK: begin
          nxt_imask = wb_sel_i[0] ? wb_dat_i[`MTL_IRQ_W-1:0] : imask_ff;
        end
        default: begin
          nxt_imask = imask_ff;
        end
      endcase
    end
    if (rd) begin
      case (wb_adr_i)
        `MTL_ADR_STATUS: nxt_rdat = {24'h000000, status_ff};
        `MTL_ADR_ACCESS: nxt_rdat = access_ff;
        `MTL_ADR_PERMIT: nxt_rdat = permit_ff;
        `MTL_ADR_IRQ_STAT: nxt_rdat = {29'h0000_0000, istat_ff};
        `MTL_ADR_IRQ_MASK: nxt_rdat = {29'h0000_0000, imask_ff};
        `MTL_ADR_RESULT: nxt_rdat = {cnt_ff, 8'h00, 1'b0, !ready_ff, op_ff, 2'b00, dir_ff};
        default: nxt_rdat = 32'h0000_0000;
      endcase
    end
    // A new event beats a same-cycle clear so it is never lost
    nxt_istat = (istat_ff & ~w1c) | {ev_unimpl, ev_level, ev_trap};
    nxt_irq = |(nxt_istat & nxt_imask);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_ff <= `MTL_STATUS_RST;
      access_ff <= `MTL_ACCESS_RST;
      permit_ff <= `MTL_PERMIT_RST;
      istat_ff <= `MTL_IRQ_RST;
      imask_ff <= `MTL_IRQ_RST;
      rdat_ff <= 32'h0000_0000;
      ack_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      access_ff <= nxt_access;
      permit_ff <= nxt_permit;
      istat_ff <= nxt_istat;
      imask_ff <= nxt_imask;
      rdat_ff <= nxt_rdat;
      ack_ff <= nxt_ack;
      irq_ff <= nxt_irq;
    end
  end

  assign wb_dat_o = rdat_ff;
  assign wb_ack_o = ack_ff;
  assign cmd_ready_o = ready_ff;
  assign reg_req_o = req_ff;
  assign reg_sel_o = sel_ff;
  assign rsp_valid_o = rsp_valid_ff;
  assign rsp_dir_o = dir_ff;
  assign irq_o = irq_ff;

endmodule

// ==== sim/mtl_checker.sv ====
// Port-level checker for the trap and level-check unit.
// Assumes it is bound to mtl_unit and sees only its ports.
`include "mtl_cfg.svh"
module mtl_checker (
  input wire logic clk_i,            // Clock
  input wire logic rst_i,            // Reset
  input wire logic wb_cyc_i,         // Bus cycle
  input wire logic wb_stb_i,         // Bus strobe
  input wire logic wb_ack_o,         // Bus acknowledge
  input wire logic cmd_valid_i,      // Command offered
  input wire logic cmd_ready_o,      // Unit ready
  input wire logic [1:0] cmd_op_i,   // Command kind
  input wire logic [15:0] cmd_word_i, // Command word
  input wire logic reg_req_o,        // Register wanted
  input wire logic reg_valid_i,      // Register supplied
  input wire logic rsp_valid_o,      // Directive valid
  input wire logic [1:0] rsp_dir_o   // Directive
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic take;
  assign take = cmd_valid_i && cmd_ready_o;
  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bus answer late");
  property p_rsp_time;
    take && cmd_op_i != 2'b10 |=> !cmd_ready_o && !rsp_valid_o ##1 rsp_valid_o && cmd_ready_o;
  endproperty
  a_rsp_time: assert property (p_rsp_time) else $error("directive timing");
  property p_reg_req;
    take && cmd_op_i == 2'b10 && cmd_word_i[15:3] == `MTL_CHK_EXT |=> reg_req_o && !cmd_ready_o;
  endproperty
  a_reg_req: assert property (p_reg_req) else $error("no register request");
  property p_reg_rsp;
    reg_req_o && reg_valid_i |=> !reg_req_o ##1 rsp_valid_o;
  endproperty
  a_reg_rsp: assert property (p_reg_rsp) else $error("register answer timing");
  property p_no_reg;
    take && cmd_op_i == 2'b01 |=> !reg_req_o [*2];
  endproperty
  a_no_reg: assert property (p_no_reg) else $error("register asked for");
  property p_rsp_pulse;
    rsp_valid_o |=> !rsp_valid_o;
  endproperty
  a_rsp_pulse: assert property (p_rsp_pulse) else $error("directive too long");
  property p_ready_back;
    rsp_valid_o |-> cmd_ready_o && !reg_req_o;
  endproperty
  a_ready_back: assert property (p_ready_back) else $error("not ready at answer");
  property p_dir_hold;
    !rsp_valid_o && !$past(rst_i) |-> $stable(rsp_dir_o);
  endproperty
  a_dir_hold: assert property (p_dir_hold) else $error("directive moved");
endmodule

bind mtl_unit mtl_checker mtl_checker_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .cmd_valid_i(cmd_valid_i),
  .cmd_ready_o(cmd_ready_o), .cmd_op_i(cmd_op_i), .cmd_word_i(cmd_word_i),
  .reg_req_o(reg_req_o), .reg_valid_i(reg_valid_i), .rsp_valid_o(rsp_valid_o),
  .rsp_dir_o(rsp_dir_o));

// ==== sim/mtl_host_model.sv ====
// Host processor model: offers commands and supplies address registers.
// Assumes the unit's clock; tasks are called just after a rising edge.
module mtl_host_model
  import mtl_pkg::*;
(
  input wire logic clk_i,            // Clock
  output logic cmd_valid_o,          // Command offered
  input wire logic cmd_ready_i,      // Unit ready
  output logic [1:0] cmd_op_o,       // Command kind
  output logic [15:0] cmd_word_o,    // Condition or extension word
  output logic [31:0] cmd_ea_o,      // Destination pointer
  input wire logic reg_req_i,        // Register wanted
  input wire logic [2:0] reg_sel_i,  // Register number
  output logic reg_valid_o,          // Register supplied
  output logic [31:0] reg_data_o,    // Register contents
  input wire logic rsp_valid_i,      // Directive valid
  input wire logic [1:0] rsp_dir_i   // Directive
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] areg [8];
  int lag = 0;
  int pc = 0;  // Host instruction address in bytes, advanced past each trap
  initial begin
    {cmd_valid_o, cmd_op_o, cmd_word_o, cmd_ea_o} = '0;
    {reg_valid_o, reg_data_o} = {1'b0, 32'hA5A5_A5A5};
    forever begin
      @(posedge clk_i);
      if (reg_valid_o) begin
        reg_valid_o <= 1'b0;
        reg_data_o <= ~reg_data_o;  // Released lines do not keep the value
      end else if (reg_req_i) begin
        repeat (lag) @(posedge clk_i);
        reg_valid_o <= 1'b1;
        reg_data_o <= areg[reg_sel_i];
      end
    end
  end
  // Only the condition or extension word is forwarded; operand words stay with the host
  task automatic issue(input logic [1:0] op, input logic [15:0] w, input logic [31:0] ea,
                       output logic [1:0] dir);
    cmd_valid_o <= 1'b1;
    {cmd_op_o, cmd_word_o, cmd_ea_o} <= {op, w, ea};
    do @(posedge clk_i); while (cmd_ready_i !== 1'b1);
    cmd_valid_o <= 1'b0;
    {cmd_op_o, cmd_word_o, cmd_ea_o} <= ~{op, w, ea};
    // Only the bench's cycle ceiling ends a wait for an answer that never comes
    do @(posedge clk_i); while (rsp_valid_i !== 1'b1);
    dir = rsp_dir_i;
  endtask
  // Operand words after the condition word; a negative count is an undefined selector
  function automatic int trail_words(input logic [2:0] opmode);
    case (opmode)
      3'h2: return 1;
      3'h3: return 2;
      3'h4: return 0;
      default: return -1;
    endcase
  endfunction
  // Only control-alterable modes name a pointer; the rest never reach the unit
  function automatic logic ea_ok(input logic [5:0] ea_field);
    case (ea_field[5:3])
      3'h2, 3'h5, 3'h6: return 1'b1;
      3'h7: return ea_field[2:1] == 2'b00;
      default: return 1'b0;
    endcase
  endfunction
  task automatic cond_trap(input logic [2:0] opmode, input logic [15:0] w,
                           output logic [1:0] dir);
    int n;
    n = trail_words(opmode);
    if (n < 0) begin
      dir = MTL_DIR_UNIMPL;
    end else begin
      issue(MTL_OP_TRAP, w, 32'h0, dir);
      pc = pc + 4 + 2 * n;
    end
  endtask
  task automatic level_check(input logic [1:0] op, input logic [15:0] w, input logic [5:0] eaf,
                             input logic [31:0] ea, output logic [1:0] dir);
    if (!ea_ok(eaf)) begin
      dir = MTL_DIR_UNIMPL;
    end else begin
      issue(op, w, ea, dir);
    end
  endtask
endmodule

// ==== sim/tb_top.sv ====
// Self-checking bench for the trap and level-check unit.
// Assumes the host model drives the command port and this module the bus.
`include "mtl_cfg.svh"
module tb_top
  import mtl_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, cyc, stb, we, ack, irq, cv, cr, rq, rv, rsv;
  logic [7:0] adr, st;
  logic [31:0] wdat, rdat, ea, rd, q, a;
  logic [1:0] op, rdir, e;
  logic [15:0] wrd;
  logic [2:0] rs;
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;
  mtl_unit mtl_unit_i (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .cmd_valid_i(cv), .cmd_ready_o(cr), .cmd_op_i(op), .cmd_word_i(wrd), .cmd_ea_i(ea),
    .reg_req_o(rq), .reg_sel_o(rs), .reg_valid_i(rv), .reg_data_i(rd), .rsp_valid_o(rsv),
    .rsp_dir_o(rdir), .irq_o(irq));
  mtl_host_model mtl_host_model_i (.clk_i(clk), .cmd_valid_o(cv), .cmd_ready_i(cr),
    .cmd_op_o(op), .cmd_word_o(wrd), .cmd_ea_o(ea), .reg_req_i(rq), .reg_sel_i(rs),
    .reg_valid_o(rv), .reg_data_o(rd), .rsp_valid_i(rsv), .rsp_dir_i(rdir));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // A hung handshake would stall forever; the whole run needs well under this
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      fail_count++;
      results();
    end
  end
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_compared++;
    if (g !== x) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, ad, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    {cyc, stb} <= 2'b00;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [7:0] ad, input logic [31:0] x);
    wb(1'b0, ad, 32'h0);
    chk("register", x, q);
  endtask
  task automatic cmd(input logic [1:0] o, input logic [15:0] w, input logic [31:0] p,
                     input logic [1:0] x);
    logic [1:0] d;
    mtl_host_model_i.issue(o, w, p, d);
    chk("directive", {30'h0, x}, {30'h0, d});
  endtask
  task automatic trp(input logic [2:0] m, input logic [15:0] w, input logic [1:0] x);
    logic [1:0] d;
    mtl_host_model_i.cond_trap(m, w, d);
    chk("directive", {30'h0, x}, {30'h0, d});
  endtask
  task automatic lvc(input logic [1:0] o, input logic [15:0] w, input logic [5:0] m,
                     input logic [31:0] p, input logic [1:0] x);
    logic [1:0] d;
    mtl_host_model_i.level_check(o, w, m, p, d);
    chk("directive", {30'h0, x}, {30'h0, d});
  endtask
  initial begin
    rst = 1'b1;
    {cyc, stb, we, adr, wdat} = '0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wb(1'b1, 8'h18, 32'hFFFF_FFFF);
    for (int i = 0; i < 7; i++)
      rdc(8'(4 * i), (i == 5) ? {26'h0, MTL_OP_NONE, 4'h0} : 32'h0);
    $display("test reset done");
    for (int p = 0; p < 2; p++) begin
      st = p ? 8'hA5 : 8'h5A;
      wb(1'b1, `MTL_ADR_STATUS, {24'h0, st});
      for (int c = 0; c < 16; c++) begin
        e = (st[c / 2] ^ c[0]) ? MTL_DIR_TRAP : MTL_DIR_PROCEED;
        trp(3'(2 + c % 3), 16'(c), e);
      end
      rdc(`MTL_ADR_STATUS, {24'h0, st});
    end
    cmd(MTL_OP_TRAP, 16'h0010, 32'h0, MTL_DIR_UNIMPL);
    trp(3'h5, 16'h0000, MTL_DIR_UNIMPL);
    chk("next address", 32'h0000_00C0, 32'(mtl_host_model_i.pc));
    $display("test condition done");
    wb(1'b1, `MTL_ADR_PERMIT, 32'h9000_0000);
    cmd(MTL_OP_CHK_PERMIT, 16'h2800, 32'hF000_0000, MTL_DIR_LEVEL_EXC);
    for (int w = 0; w < 8; w++) begin
      wb(1'b1, `MTL_ADR_ACCESS, {23'h0, 1'b1, 5'h0, 3'(w)});
      for (int k = 0; k < 2; k++) begin
        a = k ? 32'hF000_0000 : 32'h8FFF_FFFF;
        e = (32'h9000_0000 >> (31 - w)) > (a >> (31 - w)) ? MTL_DIR_LEVEL_EXC : MTL_DIR_PROCEED;
        lvc(MTL_OP_CHK_PERMIT, 16'h2800, k ? 6'h2B : 6'h39, a, e);
      end
    end
    lvc(MTL_OP_CHK_PERMIT, 16'h2800, 6'h18, 32'h0, MTL_DIR_UNIMPL);
    lvc(MTL_OP_CHK_AREG, 16'h2800, 6'h3C, 32'h0, MTL_DIR_UNIMPL);
    cmd(MTL_OP_CHK_PERMIT, 16'h2801, 32'h0, MTL_DIR_UNIMPL);
    cmd(MTL_OP_NONE, 16'h0000, 32'h0, MTL_DIR_UNIMPL);
    wb(1'b1, `MTL_ADR_ACCESS, 32'h0000_0102);
    for (int r = 0; r < 8; r++) begin
      mtl_host_model_i.areg[r] = {3'(r), 29'h1FFF_FFFF};
      mtl_host_model_i.lag = r % 3;
      e = r > 3 ? MTL_DIR_LEVEL_EXC : MTL_DIR_PROCEED;
      cmd(MTL_OP_CHK_AREG, 16'h2800 | 16'(r), 32'h6000_0000, e);
    end
    rdc(`MTL_ADR_STATUS, 32'h0000_00A5);
    rdc(`MTL_ADR_RESULT, 32'h003C_0022);
    $display("test level check done");
    rdc(`MTL_ADR_IRQ_STAT, 32'h7);
    chk("irq", 32'h0, {31'h0, irq});
    wb(1'b1, `MTL_ADR_IRQ_MASK, 32'h2);
    chk("irq", 32'h1, {31'h0, irq});
    wb(1'b1, `MTL_ADR_IRQ_STAT, 32'h2);
    chk("irq", 32'h0, {31'h0, irq});
    rdc(`MTL_ADR_IRQ_STAT, 32'h5);
    $display("test interrupt done");
    results();
  end
endmodule
